// ==== logic/mps_pkg.sv ====
// motor protection stages: constants, register map and carrier types
// assumes one 40 MHz clock; measurements arrive already scaled
package mps_pkg;
    localparam int unsigned CLK_PERIOD_NS  = 25;
    localparam int unsigned TICK_NS        = 100_000_000;
    localparam int unsigned TICK_CYCLES    = TICK_NS / CLK_PERIOD_NS;
    localparam int unsigned PS_TRIP_MS     = 100;
    localparam int unsigned PS_TRIP_TICKS  = PS_TRIP_MS * 1_000_000 / TICK_NS;
    localparam int unsigned RUN_BLOCK_MS   = 2000;
    localparam int unsigned RUN_BLOCK_TICKS = RUN_BLOCK_MS * 1_000_000 / TICK_NS;
    localparam int unsigned NS_MAX_S       = 1000;
    localparam int unsigned NS_MAX_TICKS   = NS_MAX_S * (1_000_000_000 / TICK_NS);
    localparam int unsigned NS_K1_SCALE    = 10_000_000;
    // register byte addresses and group word indices
    localparam logic [9:0] ADDR_CTRL   = 10'h000;
    localparam logic [9:0] ADDR_STATUS = 10'h004;
    localparam logic [9:0] ADDR_VT     = 10'h008;
    localparam logic [9:0] ADDR_CT     = 10'h00c;
    localparam logic [1:0] GRP_PAGE    = 2'h1;
    localparam logic [3:0] W_PW0_SET = 4'h0, W_PW0_DLY = 4'h1, W_PW1_SET = 4'h2;
    localparam logic [3:0] W_PW1_DLY = 4'h3, W_UC_SET = 4'h4, W_UC_DLY = 4'h5;
    localparam logic [3:0] W_NS_SET = 4'h6, W_NS_DLY = 4'h7, W_NS_MODE = 4'h8;
    // setting limits, 0.5 % / 0.1 s / 1 % / 1 s units
    localparam int PW_SET_MIN = -400, PW_SET_MAX = 400, PW_UV_SET_MIN = 2;
    localparam int DLY_MIN = 3, DLY_MAX = 3000, NS_DLY_MIN = 10, NS_DLY_MAX = 6000;
    localparam int UC_SET_MIN = 20, UC_SET_MAX = 70, NS_SET_MIN = 2, NS_SET_MAX = 70;
    localparam int K1_MIN = 1, K1_MAX = 50;
    // fixed levels in per-mille of rated, mA, percent
    localparam int unsigned UC_BLOCK_PM = 150, PW_UV_PM = 50, NS_SEC_MA = 250;
    localparam int unsigned PS_RATIO_PCT = 80, PS_MEAN_PM = 200, PS_PHASE_PM = 200;
    localparam int unsigned RUN_LO_PM = 200, RUN_HI_PM = 1200;
    localparam int unsigned UC_RR_PCT = 105, NS_RR_PCT = 95, PW_RR_DIV = 20;
    localparam int unsigned SQRT3_Q10 = 1774;
    // stage indices in the start and trip vectors
    localparam int ST_PW0 = 0, ST_PW1 = 1, ST_UC = 2, ST_NS = 3, ST_PS = 4;
    localparam int N_STAGE = 5;
    localparam int unsigned N_GRP = 4;
    typedef enum logic [1:0] {
        MOT_STOP = 2'b00,
        MOT_RUN  = 2'b01,
        MOT_LONG = 2'b11
    } mps_motor_t;
    typedef struct packed {
        logic [9:0]  addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } mps_bus_t;
    typedef struct packed {
        logic [2:0][15:0]   i_ph_pm;
        logic [2:0][15:0]   i_sec_ma;
        logic [15:0]        u_max_pm;
        logic signed [31:0] p_act;
        logic [15:0]        i_neg_pm;
        logic [15:0]        i_pos_pm;
    } mps_meas_t;
    typedef struct packed {
        logic [1:0][9:0]  pw_set;
        logic [1:0][11:0] pw_dly;
        logic [6:0]       uc_set;
        logic [11:0]      uc_dly;
        logic [6:0]       ns_set;
        logic [12:0]      ns_dly;
        logic             ns_def;
        logic [5:0]       ns_k1;
    } mps_grp_t;
    localparam mps_grp_t GRP_RST = '{pw_set: {10'h3f6, 10'h3f6}, pw_dly: {12'h00a, 12'h00a},
        uc_set: 7'h14, uc_dly: 12'h00a, ns_set: 7'h0a, ns_dly: 13'h000a,
        ns_def: 1'b1, ns_k1: 6'h0f};
endpackage

// ==== logic/mps_top.sv ====
// motor protection stages: power, undercurrent, negative sequence, phase sequence
// assumes scaled measurements synchronous to clk_in and a simple register port
//
// Overview of operation
// - power stage starts while active power is below its signed start value
// - power stage trips once start outlasts its operate delay
// - power start setting spans -200 % to +200 % of rated in 0.5 % steps
// - rated apparent power is VT primary times CT primary times root three
// - two identical power stages, each with its own settings
// - power operate delay 0.3 s to 300 s in 0.1 s steps
// - positive power setting of 1 % or more blocks below 5 % voltage
// - four setting groups; the active one feeds the power, undercurrent and negative sequence settings
// - undercurrent uses fundamental phase currents, definite delay only
// - undercurrent blocked while all three currents are below 15 %
// - undercurrent operate delay 0.3 s to 300 s in 0.1 s steps
// - negative sequence stage offers definite and dependent delay
// - dependent time is multiplier over squared current minus squared setting
// - dependent delay never exceeds 1000 s
// - negative sequence definite delay 1 s to 600 s in 0.1 s steps
// - negative sequence stage works only while all secondaries exceed 250 mA
// - phase sequence starts above 80 % ratio and 0.2 mean, trips 100 ms on
// - phase sequence blocked after 2 s of continuous running
// - phase sequence works only while a phase exceeds 0.2 nominal
// - phase sequence has one fixed setting set, ignoring group select
// - running means mean current between 20 % and 120 % of nominal
`timescale 1ns/1ps
module mps_top #(
    parameter int unsigned TICK_CYCLES = mps_pkg::TICK_CYCLES
) (
    // clock and reset
    input  wire logic                clk_in,
    input  wire logic                sys_rst_in,
    // register port
    input  wire mps_pkg::mps_bus_t   bus_in,
    output logic [31:0]              rdata_out,
    // measurements and external blocks
    input  wire mps_pkg::mps_meas_t  meas_in,
    input  wire logic [4:0]          block_in,
    // stage outputs
    output logic [4:0]               start_out,
    output logic [4:0]               trip_out,
    output logic                     motor_run_out
);
    localparam int NS = mps_pkg::N_STAGE;

    // registers
    logic [1:0]         grp_sel_reg;
    logic [15:0]        vt_reg;
    logic [15:0]        ct_reg;
    mps_pkg::mps_grp_t  grp_reg [mps_pkg::N_GRP];
    logic [31:0]        rdata_reg;
    logic [23:0]        tick_cnt_reg;
    logic               tick_reg;
    mps_pkg::mps_motor_t mot_reg;
    logic [4:0]         run_cnt_reg;
    logic [NS-1:0]      st_reg;
    logic [NS-1:0]      tr_reg;
    logic [13:0]        cnt_reg [NS];
    logic [39:0]        acc_reg;

    // decode
    wire        wr_glob  = bus_in.wr && (bus_in.addr[9:8] == 2'h0);
    wire        wr_grp   = bus_in.wr && (bus_in.addr[9:8] == mps_pkg::GRP_PAGE);
    wire [1:0]  wr_g     = bus_in.addr[7:6];
    wire [3:0]  word_idx = bus_in.addr[5:2];
    wire [31:0] wd       = bus_in.wdata;

    function automatic logic [12:0] clampu(input logic [31:0] v, input int lo, input int hi);
        logic [12:0] r;
        r = v[12:0];
        if (v < 32'(lo)) r = 13'(lo);
        else if (v > 32'(hi)) r = 13'(hi);
        return r;
    endfunction

    function automatic logic [9:0] clamps(input logic [31:0] v);
        logic signed [31:0] s;
        s = signed'(v);
        if (s < mps_pkg::PW_SET_MIN) s = mps_pkg::PW_SET_MIN;
        else if (s > mps_pkg::PW_SET_MAX) s = mps_pkg::PW_SET_MAX;
        return s[9:0];
    endfunction

    // settings writes, out-of-range values clamp to the nearest limit
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            grp_sel_reg <= 2'h0;
            vt_reg      <= 16'h0001;
            ct_reg      <= 16'h0001;
            for (int g = 0; g < mps_pkg::N_GRP; g++) grp_reg[g] <= mps_pkg::GRP_RST;
        end else if (wr_glob) begin
            case (bus_in.addr)
                mps_pkg::ADDR_CTRL: grp_sel_reg <= wd[1:0];
                mps_pkg::ADDR_VT:   vt_reg <= wd[15:0];
                mps_pkg::ADDR_CT:   ct_reg <= wd[15:0];
                default: ;
            endcase
        end else if (wr_grp) begin
            case (word_idx)
                mps_pkg::W_PW0_SET: grp_reg[wr_g].pw_set[0] <= clamps(wd);
                mps_pkg::W_PW1_SET: grp_reg[wr_g].pw_set[1] <= clamps(wd);
                mps_pkg::W_PW0_DLY:
                    grp_reg[wr_g].pw_dly[0] <= 12'(clampu(wd, mps_pkg::DLY_MIN,
                                                          mps_pkg::DLY_MAX));
                mps_pkg::W_PW1_DLY:
                    grp_reg[wr_g].pw_dly[1] <= 12'(clampu(wd, mps_pkg::DLY_MIN,
                                                          mps_pkg::DLY_MAX));
                mps_pkg::W_UC_SET:
                    grp_reg[wr_g].uc_set <= 7'(clampu(wd, mps_pkg::UC_SET_MIN,
                                                      mps_pkg::UC_SET_MAX));
                mps_pkg::W_UC_DLY:
                    grp_reg[wr_g].uc_dly <= 12'(clampu(wd, mps_pkg::DLY_MIN,
                                                       mps_pkg::DLY_MAX));
                mps_pkg::W_NS_SET:
                    grp_reg[wr_g].ns_set <= 7'(clampu(wd, mps_pkg::NS_SET_MIN,
                                                      mps_pkg::NS_SET_MAX));
                mps_pkg::W_NS_DLY:
                    grp_reg[wr_g].ns_dly <= clampu(wd, mps_pkg::NS_DLY_MIN,
                                                   mps_pkg::NS_DLY_MAX);
                mps_pkg::W_NS_MODE: begin
                    grp_reg[wr_g].ns_def <= wd[0];
                    grp_reg[wr_g].ns_k1  <= 6'(clampu({8'h00, wd[31:8]},
                                                      mps_pkg::K1_MIN, mps_pkg::K1_MAX));
                end
                default: ;
            endcase
        end
    end

    // read mux
    mps_pkg::mps_grp_t rg;
    assign rg = grp_reg[bus_in.addr[7:6]];
    wire [31:0] status_w = {15'h0, mot_reg, grp_sel_reg, motor_run_out, 2'h0,
                            tr_reg, st_reg};
    logic [31:0] grp_rd_w;
    always_comb begin
        case (word_idx)
            mps_pkg::W_PW0_SET: grp_rd_w = 32'(signed'(rg.pw_set[0]));
            mps_pkg::W_PW0_DLY: grp_rd_w = {20'h0, rg.pw_dly[0]};
            mps_pkg::W_PW1_SET: grp_rd_w = 32'(signed'(rg.pw_set[1]));
            mps_pkg::W_PW1_DLY: grp_rd_w = {20'h0, rg.pw_dly[1]};
            mps_pkg::W_UC_SET:  grp_rd_w = {25'h0, rg.uc_set};
            mps_pkg::W_UC_DLY:  grp_rd_w = {20'h0, rg.uc_dly};
            mps_pkg::W_NS_SET:  grp_rd_w = {25'h0, rg.ns_set};
            mps_pkg::W_NS_DLY:  grp_rd_w = {19'h0, rg.ns_dly};
            mps_pkg::W_NS_MODE: grp_rd_w = {18'h0, rg.ns_k1, 7'h0, rg.ns_def};
            default:            grp_rd_w = 32'h0;
        endcase
    end
    wire [31:0] rd_mux_w =
        (bus_in.addr == mps_pkg::ADDR_CTRL)   ? {30'h0, grp_sel_reg} :
        (bus_in.addr == mps_pkg::ADDR_STATUS) ? status_w :
        (bus_in.addr == mps_pkg::ADDR_VT)     ? {16'h0, vt_reg} :
        (bus_in.addr == mps_pkg::ADDR_CT)     ? {16'h0, ct_reg} :
        (bus_in.addr[9:8] == mps_pkg::GRP_PAGE) ? grp_rd_w : 32'h0;

    // read data stands for exactly one cycle
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) rdata_reg <= 32'h0;
        else rdata_reg <= bus_in.rd ? rd_mux_w : 32'h0;
    end
    assign rdata_out = rdata_reg;

    // 0.1 s time base shared by every stage timer
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            tick_cnt_reg <= 24'h0;
            tick_reg     <= 1'b0;
        end else begin
            tick_reg     <= (tick_cnt_reg == 24'(TICK_CYCLES - 1));
            tick_cnt_reg <= (tick_cnt_reg == 24'(TICK_CYCLES - 1)) ? 24'h0
                                                                   : tick_cnt_reg + 24'h1;
        end
    end

    // measurement derived values
    mps_pkg::mps_grp_t cg;
    assign cg = grp_reg[grp_sel_reg];
    wire [17:0] i_mean_w = 18'((18'(meas_in.i_ph_pm[0]) + 18'(meas_in.i_ph_pm[1])
                                + 18'(meas_in.i_ph_pm[2])) / 18'd3);
    wire signed [63:0] sn_w =
        64'((64'(vt_reg) * 64'(ct_reg) * 64'(mps_pkg::SQRT3_Q10)) >> 10);
    wire signed [63:0] p200_w = 64'(meas_in.p_act) * 64'sd200;
    logic [2:0] uc_lo_w, uc_hold_w, uc_blk_w, sec_ok_w, ps_ph_w;
    wire [15:0] uc_thr_w  = 16'(cg.uc_set) * 16'd10;
    wire [15:0] uc_rel_w  = 16'(32'(uc_thr_w) * mps_pkg::UC_RR_PCT / 100);
    for (genvar p = 0; p < 3; p++) begin : g_ph
        assign uc_lo_w[p]   = meas_in.i_ph_pm[p] < uc_thr_w;
        assign uc_hold_w[p] = meas_in.i_ph_pm[p] < uc_rel_w;
        assign uc_blk_w[p]  = meas_in.i_ph_pm[p] < 16'(mps_pkg::UC_BLOCK_PM);
        assign sec_ok_w[p]  = meas_in.i_sec_ma[p] > 16'(mps_pkg::NS_SEC_MA);
        assign ps_ph_w[p]   = meas_in.i_ph_pm[p] > 16'(mps_pkg::PS_PHASE_PM);
    end
    wire [15:0] ns_thr_w = 16'(cg.ns_set) * 16'd10;
    wire [15:0] ns_rel_w = 16'(32'(ns_thr_w) * mps_pkg::NS_RR_PCT / 100);
    wire        run_w    = (i_mean_w >= 18'(mps_pkg::RUN_LO_PM))
                        && (i_mean_w <= 18'(mps_pkg::RUN_HI_PM));
    wire        ps_ratio_w = 32'(meas_in.i_neg_pm) * 32'd100
                          > 32'(meas_in.i_pos_pm) * 32'(mps_pkg::PS_RATIO_PCT);

    // per-stage condition, block and limit feeding one generic timer
    logic [NS-1:0] act_w, blk_w;
    logic [13:0]   lim_w [NS];
    for (genvar k = 0; k < 2; k++) begin : g_pw
        wire signed [63:0] thr   = 64'(signed'(cg.pw_set[k])) * sn_w;
        wire signed [63:0] hyst  = (thr < 0 ? -thr : thr) / 64'sd20;
        wire               uvblk = (signed'(cg.pw_set[k]) >= 10'(mps_pkg::PW_UV_SET_MIN))
                                && (meas_in.u_max_pm < 16'(mps_pkg::PW_UV_PM));
        assign act_w[k] = st_reg[k] ? (p200_w < thr + hyst) : (p200_w < thr);
        assign blk_w[k] = block_in[k] | uvblk;
        assign lim_w[k] = 14'(cg.pw_dly[k]);
    end
    assign act_w[mps_pkg::ST_UC] = st_reg[mps_pkg::ST_UC] ? |uc_hold_w : |uc_lo_w;
    assign blk_w[mps_pkg::ST_UC] = block_in[mps_pkg::ST_UC] | &uc_blk_w;
    assign lim_w[mps_pkg::ST_UC] = 14'(cg.uc_dly);
    assign act_w[mps_pkg::ST_NS] = st_reg[mps_pkg::ST_NS] ? (meas_in.i_neg_pm >= ns_rel_w)
                                                          : (meas_in.i_neg_pm > ns_thr_w);
    assign blk_w[mps_pkg::ST_NS] = block_in[mps_pkg::ST_NS] | ~&sec_ok_w;
    assign lim_w[mps_pkg::ST_NS] = cg.ns_def ? 14'(cg.ns_dly)
                                             : 14'(mps_pkg::NS_MAX_TICKS);
    // fixed levels only, so group selection has no effect here
    assign act_w[mps_pkg::ST_PS] = ps_ratio_w
                                && (i_mean_w > 18'(mps_pkg::PS_MEAN_PM));
    assign blk_w[mps_pkg::ST_PS] = block_in[mps_pkg::ST_PS] | ~|ps_ph_w
                                 | (mot_reg == mps_pkg::MOT_LONG);
    assign lim_w[mps_pkg::ST_PS] = 14'(mps_pkg::PS_TRIP_TICKS);

    // dependent delay: integrate (i2^2 - k2^2) per tick until k1 is reached
    wire [31:0] i2sq_w  = 32'(meas_in.i_neg_pm) * 32'(meas_in.i_neg_pm);
    wire [31:0] k2sq_w  = 32'(ns_thr_w) * 32'(ns_thr_w);
    wire [39:0] k1_lim_w = 40'(cg.ns_k1) * 40'(mps_pkg::NS_K1_SCALE);
    wire        dep_hit_w = !cg.ns_def && (acc_reg >= k1_lim_w);
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) acc_reg <= 40'h0;
        else if (blk_w[mps_pkg::ST_NS] || !act_w[mps_pkg::ST_NS] || cg.ns_def)
            acc_reg <= 40'h0;
        else if (tick_reg && (i2sq_w > k2sq_w) && !dep_hit_w)
            acc_reg <= acc_reg + 40'(i2sq_w - k2sq_w);
    end

    for (genvar k = 0; k < NS; k++) begin : g_tmr
        wire dep = (k == mps_pkg::ST_NS) && dep_hit_w;
        always_ff @(posedge clk_in or posedge sys_rst_in) begin
            if (sys_rst_in) begin
                st_reg[k]  <= 1'b0;
                tr_reg[k]  <= 1'b0;
                cnt_reg[k] <= 14'h0;
            end else if (blk_w[k] || !act_w[k]) begin
                st_reg[k]  <= 1'b0;
                tr_reg[k]  <= 1'b0;
                cnt_reg[k] <= 14'h0;
            end else begin
                st_reg[k] <= 1'b1;
                if (tick_reg && !tr_reg[k]) cnt_reg[k] <= cnt_reg[k] + 14'h1;
                if ((tick_reg && cnt_reg[k] + 14'h1 >= lim_w[k]) || dep)
                    tr_reg[k] <= 1'b1;
            end
        end
    end
    assign start_out = st_reg;
    assign trip_out  = tr_reg;

    // motor state: running timer blocks the phase sequence stage
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            mot_reg     <= mps_pkg::MOT_STOP;
            run_cnt_reg <= 5'h0;
        end else begin
            case (mot_reg)
                mps_pkg::MOT_STOP: begin
                    run_cnt_reg <= 5'h0;
                    if (run_w) mot_reg <= mps_pkg::MOT_RUN;
                end
                mps_pkg::MOT_RUN: begin
                    if (!run_w) mot_reg <= mps_pkg::MOT_STOP;
                    else if (tick_reg) begin
                        run_cnt_reg <= run_cnt_reg + 5'h1;
                        if (run_cnt_reg + 5'h1 >= 5'(mps_pkg::RUN_BLOCK_TICKS))
                            mot_reg <= mps_pkg::MOT_LONG;
                    end
                end
                mps_pkg::MOT_LONG: if (!run_w) mot_reg <= mps_pkg::MOT_STOP;
                default: mot_reg <= mps_pkg::MOT_STOP;
            endcase
        end
    end
    // run and long share bit 0, so the pin comes straight from the state flop
    assign motor_run_out = mot_reg[0];

    // checks
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (sys_rst_in);

    sequence s_pw_fault;
        !blk_w[0] && act_w[0];
    endsequence
    sequence s_ps_fire;
        st_reg[mps_pkg::ST_PS] && !blk_w[mps_pkg::ST_PS] && act_w[mps_pkg::ST_PS]
            && tick_reg;
    endsequence

    AST_PW_START: assert property (s_pw_fault |=> st_reg[0])
        else $error("power stage did not start on low power");
    AST_PW_TRIP_NEEDS_START: assert property (tr_reg[0] |-> st_reg[0])
        else $error("power trip without start");
    AST_PW_UV_BLOCK: assert property (blk_w[1] |=> !st_reg[1] && cnt_reg[1] == 14'h0)
        else $error("blocked power stage kept running");
    AST_UC_BLOCK: assert property (&uc_blk_w |=> !st_reg[mps_pkg::ST_UC])
        else $error("undercurrent started below block limit");
    AST_NS_GATE: assert property (!(&sec_ok_w) |=> !st_reg[mps_pkg::ST_NS])
        else $error("negative sequence ran with low secondary current");
    AST_NS_CLAMP: assert property (cnt_reg[mps_pkg::ST_NS] <= 14'd10000)
        else $error("negative sequence delay beyond 1000 s");
    AST_PS_TRIP: assert property (s_ps_fire |=> tr_reg[mps_pkg::ST_PS])
        else $error("phase sequence did not trip one tick after start");
    AST_PS_RUN_BLOCK: assert property
        (mot_reg == mps_pkg::MOT_LONG |=> !st_reg[mps_pkg::ST_PS])
        else $error("phase sequence active after long running");
    AST_TMR_RESTART: assert property (!st_reg[2] |-> cnt_reg[2] == 14'h0)
        else $error("undercurrent timer not cleared at release");
    AST_RD_ONE_CYCLE: assert property
        (!bus_in.rd |=> rdata_out == 32'h0)
        else $error("read data outside read cycle");
endmodule // mps_top

// ==== test/motor_protection_stages_tb.sv ====
// self-checking bench for the motor protection stages
// assumes mps_top with a short tick and the measurement model beside it
`timescale 1ns/1ps
module motor_protection_stages_tb;
    localparam int TC = 4;
    logic               clk_in     = 1'b0;
    logic               sys_rst_in = 1'b1;
    mps_pkg::mps_bus_t  bus        = '0;
    mps_pkg::mps_meas_t m_set      = '0;
    mps_pkg::mps_meas_t meas;
    mps_pkg::mps_meas_t v;
    logic [4:0]         blk        = '0;
    logic [4:0]         start;
    logic [4:0]         trip;
    logic [31:0]        rdata;
    logic               run;
    int                 err_count  = 0;
    int                 n_compared = 0;
    int                 n;

    always #12.5 clk_in = ~clk_in;

    mps_top #(.TICK_CYCLES(TC)) i_mps_top (
        .clk_in(clk_in), .sys_rst_in(sys_rst_in), .bus_in(bus), .rdata_out(rdata),
        .meas_in(meas), .block_in(blk), .start_out(start), .trip_out(trip),
        .motor_run_out(run));
    mps_meas_model i_mps_meas_model (
        .clk_in(clk_in), .sys_rst_in(sys_rst_in), .meas_in(m_set), .meas_out(meas));

    task automatic results();
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic cyc(input int k);
        repeat (k) @(posedge clk_in);
        #1;
    endtask

    task automatic wr(input logic [9:0] a, input logic [31:0] d);
        @(posedge clk_in);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk_in);
        bus.wr <= 1'b0;
    endtask

    // read data stands only in the cycle after the strobe
    task automatic rd(input logic [9:0] a, input logic [31:0] exp);
        @(posedge clk_in);
        bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
        @(posedge clk_in);
        bus.rd <= 1'b0;
        #1;
        chk(rdata, exp);
    endtask

    // model lag plus one registered stage, with a spare cycle
    task automatic setm(input mps_pkg::mps_meas_t t);
        @(posedge clk_in);
        m_set <= t;
        cyc(3);
    endtask

    task automatic wait_trip(input int idx, input int lim);
        n = 0;
        while (trip[idx] !== 1'b1 && n < lim) begin
            cyc(1);
            n++;
        end
        if (trip[idx] !== 1'b1) begin
            err_count++;
            $display("[FAIL] %0t no trip on stage %0d", $time, idx);
            results();
        end
    endtask

    initial begin
        v = '0;
        repeat (16) @(posedge clk_in);
        sys_rst_in <= 1'b0;
        #1;
        chk({start, trip}, 32'h0);
        rd(mps_pkg::ADDR_CTRL, 32'h0);
        rd(mps_pkg::ADDR_VT, 32'h1);
        rd(10'h3fc, 32'h0);
        wr(10'h104, 32'h1);
        rd(10'h104, 32'h3);
        v.p_act = 32'hffff_ffff;
        setm(v);
        chk(start[1:0], 32'h3);
        wait_trip(0, 100);
        chk(n >= 2 * TC - 1 && n <= 3 * TC - 2, 32'h1);
        @(posedge clk_in);
        blk <= 5'h01;
        cyc(2);
        chk({start[0], trip[0]}, 32'h0);
        @(posedge clk_in);
        blk <= 5'h00;
        cyc(2);
        chk({start[0], trip[0]}, 32'h2);
        // positive setting with no voltage must hold power2 off
        wr(10'h108, 32'h1f4);
        rd(10'h108, 32'h190);
        cyc(2);
        chk(start[1:0], 32'h1);
        v.u_max_pm = 16'h0064;
        setm(v);
        chk(start[1:0], 32'h3);
        v.p_act = 32'h0;
        setm(v);
        chk(start[1:0], 32'h2);
        wr(mps_pkg::ADDR_CTRL, 32'h1);
        cyc(2);
        chk(start[1:0], 32'h0);
        v.i_ph_pm = {16'h01f4, 16'h01f4, 16'h00b4};
        setm(v);
        chk(start[2], 32'h1);
        v.i_ph_pm = {3{16'h0064}};
        setm(v);
        chk(start[2], 32'h0);
        v.i_neg_pm = 16'h00c8;
        v.i_sec_ma = {3{16'h012c}};
        setm(v);
        chk(start[3], 32'h1);
        v.i_sec_ma[0] = 16'h00c8;
        setm(v);
        chk(start[3], 32'h0);
        v.i_ph_pm = {3{16'h012c}};
        v.i_neg_pm = 16'h0384;
        v.i_pos_pm = 16'h03e8;
        setm(v);
        chk(start[4], 32'h1);
        wait_trip(4, 2 * TC + 3);
        cyc(22 * TC);
        chk({run, start[4]}, 32'h2);
        // dependent mode, multiplier clamps to 1 s: 1 / (1.0^2 - 0.1^2) is just over ten ticks
        wr(10'h160, 32'h0);
        rd(10'h160, 32'h100);
        v.i_neg_pm = 16'h03e8;
        v.i_sec_ma = {3{16'h012c}};
        setm(v);
        chk(start[3], 32'h1);
        wait_trip(3, 12 * TC);
        chk(n >= 10 * TC && n <= 11 * TC - 1, 32'h1);
        // status: long running, group 1, negative sequence started and tripped
        rd(mps_pkg::ADDR_STATUS, 32'h0001_b108);
        results();
    end
endmodule // motor_protection_stages_tb

// ==== test/mps_meas_model.sv ====
// measurement front end model: phase, sequence, voltage and power values
// assumes the bench supplies target values synchronous to clk_in
`timescale 1ns/1ps
module mps_meas_model (
    // clock and reset
    input  wire logic               clk_in,
    input  wire logic               sys_rst_in,
    // target values and refreshed measurement
    input  wire mps_pkg::mps_meas_t meas_in,
    output mps_pkg::mps_meas_t      meas_out
);
    // one clock of lag, like a filter output register; zero while in reset
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            meas_out <= '0;
        end else begin
            meas_out <= meas_in;
        end
    end
endmodule // mps_meas_model
